// [rfsc_pkg.sv]
package rfsc_pkg;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  localparam int RFSC_ADDR_WIDTH = 8;
  localparam int RFSC_DATA_WIDTH = 32;

  localparam logic [7:0] RFSC_OFF_SHORT = 8'h00;
  localparam logic [7:0] RFSC_OFF_LONG = 8'h04;
  localparam logic [7:0] RFSC_OFF_PARTIAL = 8'h08;
  localparam logic [7:0] RFSC_OFF_GROUP = 8'h0c;
  localparam logic [7:0] RFSC_OFF_MAX_LEN = 8'h10;
  localparam logic [7:0] RFSC_OFF_STATUS = 8'h14;
  localparam logic [7:0] RFSC_OFF_MASK = 8'h18;

  // ------------------------------------------------------------
  // Counters and events
  // ------------------------------------------------------------
  localparam int RFSC_NUM_COUNTERS = 4;
  localparam int RFSC_COUNT_WIDTH = 16;
  localparam int RFSC_EV_SHORT = 0;
  localparam int RFSC_EV_LONG = 1;
  localparam int RFSC_EV_PARTIAL = 2;
  localparam int RFSC_EV_GROUP = 3;

  localparam logic [7:0] RFSC_CNT_OFFSET [0:3] = '{
    8'h00, 8'h04, 8'h08, 8'h0c
  };

  // ------------------------------------------------------------
  // Frame lengths and reset values
  // ------------------------------------------------------------
  localparam int RFSC_LEN_WIDTH = 16;
  localparam logic [15:0] RFSC_SHORT_LIMIT = 16'h0040;
  localparam logic [15:0] RFSC_MAX_LEN_RESET = 16'h05ee;

  // Status bits 3..0 mark a counter reaching saturation, bit 4 a
  // length error.
  localparam int RFSC_STATUS_WIDTH = 5;
  localparam int RFSC_ST_LEN_ERR = 4;
  localparam logic [4:0] RFSC_STATUS_RESET = 5'h00;
  localparam logic [4:0] RFSC_MASK_RESET = 5'h00;

endpackage

// [rfsc_sat_counter.sv]
module rfsc_sat_counter
  import rfsc_pkg::*;
#(
  parameter int WIDTH = RFSC_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic inc,
  output logic [WIDTH-1:0] count,
  output logic reached_max
);

  localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  initial begin
    if (WIDTH < 2 || WIDTH > RFSC_DATA_WIDTH) begin
      $error("rfsc_sat_counter: WIDTH out of range");
    end
  end

  logic [WIDTH-1:0] count_reg;
  logic reached_max_reg;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // The clear is tested first so that a write landing with a frame
  // event always leaves zero behind.
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= '0;
    end else if (clear) begin
      count_reg <= '0;
    end else if (inc && count_reg != CNT_MAX) begin
      count_reg <= count_reg + CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reached_max_reg <= 1'b0;
    end else begin
      reached_max_reg <= inc && !clear && count_reg == CNT_MAX - CNT_ONE;
    end
  end

  assign count = count_reg;
  assign reached_max = reached_max_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_sat_hold: assert property (count_reg == CNT_MAX && !clear |=> count_reg == CNT_MAX)
    else $error("saturated counter moved");

  a_clear_wins: assert property (clear |=> count_reg == '0)
    else $error("clear did not zero the counter");

  a_step_one: assert property (inc && !clear && count_reg != CNT_MAX |=> count_reg == $past(count_reg) + CNT_ONE)
    else $error("counter did not step by one");

  a_idle_hold: assert property (!inc && !clear |=> $stable(count_reg))
    else $error("counter moved without an event");

endmodule

// [rfsc_rx_stat_counters.sv]
// How it works
// - Count frames shorter than 64 bytes.
// - Count frames longer than programmed maximum.
// - Long test strictly greater; maximum itself uncounted.
// - Residual-bit frames never bump long count.
// - Count frames ending with a partial byte.
// - Count frames with a multicast destination.
// - Counters are sixteen bits and saturate.
// - Any write to a counter clears it.
// - Upper sixteen bits read zero; write zeros.
// - Flag length error for short or long.
//
// Implementation choices: the address map and the strobed register port.
module rfsc_rx_stat_counters
  import rfsc_pkg::*;
#(
  parameter int COUNT_WIDTH = RFSC_COUNT_WIDTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [RFSC_ADDR_WIDTH-1:0] addr,
  input wire logic [RFSC_DATA_WIDTH-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [RFSC_DATA_WIDTH-1:0] rd_data,
  input wire logic frame_done,
  input wire logic [RFSC_LEN_WIDTH-1:0] frame_length,
  input wire logic frame_residual_bits,
  input wire logic frame_dest_group,
  output logic length_error,
  output logic irq
);

  initial begin
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > RFSC_COUNT_WIDTH) begin
      $error("rfsc_rx_stat_counters: COUNT_WIDTH out of range");
    end
  end

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic addr_hit(
    input logic [RFSC_ADDR_WIDTH-1:0] a,
    input logic [RFSC_ADDR_WIDTH-1:0] off
  );
    addr_hit = (a == off);
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [RFSC_NUM_COUNTERS-1:0] event_reg;
  logic [RFSC_NUM_COUNTERS-1:0] clear_vec;
  logic [RFSC_NUM_COUNTERS-1:0] sat_pulse;
  logic [COUNT_WIDTH-1:0] count_arr [0:RFSC_NUM_COUNTERS-1];
  logic [RFSC_LEN_WIDTH-1:0] max_len_reg;
  logic [RFSC_STATUS_WIDTH-1:0] status_reg;
  logic [RFSC_STATUS_WIDTH-1:0] status_next;
  logic [RFSC_STATUS_WIDTH-1:0] status_set;
  logic [RFSC_STATUS_WIDTH-1:0] mask_reg;
  logic [RFSC_DATA_WIDTH-1:0] rd_data_reg;
  logic [RFSC_DATA_WIDTH-1:0] rd_data_next;
  logic length_error_reg;
  logic irq_reg;
  logic frame_short;
  logic frame_over;

  // ------------------------------------------------------------
  // Frame classification
  // ------------------------------------------------------------
  // The receive path delivers the frame's verdict in one cycle at
  // its end, so each frame yields at most one pulse per counter.
  assign frame_short = frame_length < RFSC_SHORT_LIMIT;
  assign frame_over = frame_length > max_len_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      event_reg <= '0;
    end else begin
      event_reg[RFSC_EV_SHORT] <= frame_done && frame_short;
      // A frame with residual bits is booked as partial, never as long.
      event_reg[RFSC_EV_LONG] <= frame_done && frame_over
                                 && !frame_residual_bits;
      event_reg[RFSC_EV_PARTIAL] <= frame_done
                                    && frame_residual_bits;
      event_reg[RFSC_EV_GROUP] <= frame_done && frame_dest_group;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      length_error_reg <= 1'b0;
    end else begin
      length_error_reg <= frame_done && (frame_short || frame_over);
    end
  end

  // ------------------------------------------------------------
  // Counters
  // ------------------------------------------------------------
  generate
    for (genvar i = 0; i < RFSC_NUM_COUNTERS; i++) begin : g_cnt
      assign clear_vec[i] = wr_strobe
                            && addr_hit(addr, RFSC_CNT_OFFSET[i]);
      rfsc_sat_counter #(
        .WIDTH(COUNT_WIDTH)
      ) u_cnt (
        .clock(clock),
        .rst(rst),
        .clear(clear_vec[i]),
        .inc(event_reg[i]),
        .count(count_arr[i]),
        .reached_max(sat_pulse[i])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Settings registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      max_len_reg <= RFSC_MAX_LEN_RESET;
    end else if (wr_strobe && addr_hit(addr, RFSC_OFF_MAX_LEN)) begin
      max_len_reg <= wr_data[RFSC_LEN_WIDTH-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_reg <= RFSC_MASK_RESET;
    end else if (wr_strobe && addr_hit(addr, RFSC_OFF_MASK)) begin
      mask_reg <= wr_data[RFSC_STATUS_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // A read clears the status, but an event in that same cycle is
  // kept so that software never misses it.
  always_comb begin
    status_set = {length_error_reg, sat_pulse};
    if (rd_strobe && addr_hit(addr, RFSC_OFF_STATUS)) begin
      status_next = status_set;
    end else begin
      status_next = status_reg | status_set;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= RFSC_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      // A mask write is seen in the same edge, so the line never lags
      // the unmasked status by a cycle.
      if (wr_strobe && addr_hit(addr, RFSC_OFF_MASK)) begin
        irq_reg <= |(status_next & wr_data[RFSC_STATUS_WIDTH-1:0]);
      end else begin
        irq_reg <= |(status_next & mask_reg);
      end
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Data stands only in the cycle after the read strobe; at every
  // other time the port reads zero.
  always_comb begin
    rd_data_next = '0;
    if (rd_strobe) begin
      for (int k = 0; k < RFSC_NUM_COUNTERS; k++) begin
        if (addr_hit(addr, RFSC_CNT_OFFSET[k])) begin
          rd_data_next[COUNT_WIDTH-1:0] = count_arr[k];
        end
      end
      if (addr_hit(addr, RFSC_OFF_MAX_LEN)) begin
        rd_data_next[RFSC_LEN_WIDTH-1:0] = max_len_reg;
      end
      if (addr_hit(addr, RFSC_OFF_STATUS)) begin
        rd_data_next[RFSC_STATUS_WIDTH-1:0] = status_reg;
      end
      if (addr_hit(addr, RFSC_OFF_MASK)) begin
        rd_data_next[RFSC_STATUS_WIDTH-1:0] = mask_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign length_error = length_error_reg;
  assign irq = irq_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_short_end;
    frame_done && frame_length < RFSC_SHORT_LIMIT;
  endsequence

  sequence s_over_end;
    frame_done && frame_length > max_len_reg && !frame_residual_bits;
  endsequence

  sequence s_exact_max_end;
    frame_done && frame_length == max_len_reg;
  endsequence

  sequence s_counter_read;
    rd_strobe && addr < RFSC_OFF_MAX_LEN && addr[1:0] == 2'b00;
  endsequence

  a_short_event: assert property (s_short_end |=> event_reg[RFSC_EV_SHORT])
    else $error("short frame not counted");

  a_short_bump: assert property (s_short_end ##1 (!clear_vec[RFSC_EV_SHORT] && count_arr[RFSC_EV_SHORT] != {COUNT_WIDTH{1'b1}}) |=> count_arr[RFSC_EV_SHORT] == $past(count_arr[RFSC_EV_SHORT]) + 1'b1)
    else $error("short count did not advance");

  a_long_event: assert property (s_over_end |=> event_reg[RFSC_EV_LONG])
    else $error("long frame not counted");

  a_long_strict: assert property (s_exact_max_end |=> !event_reg[RFSC_EV_LONG])
    else $error("frame at maximum counted as long");

  a_residual_block: assert property (frame_done && frame_residual_bits |=> !event_reg[RFSC_EV_LONG] && event_reg[RFSC_EV_PARTIAL])
    else $error("residual frame booked as long");

  a_group_event: assert property (frame_done && frame_dest_group |=> event_reg[RFSC_EV_GROUP])
    else $error("multicast frame not counted");

  a_no_spurious: assert property (!frame_done |=> event_reg == '0)
    else $error("event without a frame end");

  a_upper_zero: assert property (s_counter_read |=> rd_data_reg[RFSC_DATA_WIDTH-1:RFSC_COUNT_WIDTH] == '0)
    else $error("counter upper bits not zero");

  a_len_error: assert property (frame_done && (frame_length < RFSC_SHORT_LIMIT || frame_length > max_len_reg) |=> length_error_reg ##1 status_reg[RFSC_ST_LEN_ERR])
    else $error("length error not flagged");

  a_write_clear: assert property (wr_strobe && addr == RFSC_OFF_GROUP |=> count_arr[RFSC_EV_GROUP] == '0)
    else $error("write did not clear counter");

  a_irq_level: assert property (|(status_reg & mask_reg) |-> irq_reg)
    else $error("interrupt low with unmasked status");

endmodule

// [rfsc_frame_source.sv]
module rfsc_frame_source
  import rfsc_pkg::*;
(
  input wire logic clock,
  output logic frame_done,
  output logic [RFSC_LEN_WIDTH-1:0] frame_length,
  output logic frame_residual_bits,
  output logic frame_dest_group
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frame_done = 1'b0;
    frame_length = 16'h0000;
    frame_residual_bits = 1'b0;
    frame_dest_group = 1'b0;
  end

  // Holds n verdicts back to back. Between verdicts the fields show the
  // inverse of the last value, so a stale sample cannot pass.
  task automatic send(input logic [15:0] len, input logic res,
                      input logic grp, input int n);
    @(posedge clock);
    frame_done <= 1'b1;
    frame_length <= len;
    frame_residual_bits <= res;
    frame_dest_group <= grp;
    repeat (n) @(posedge clock);
    frame_done <= 1'b0;
    frame_length <= ~len;
    frame_residual_bits <= ~res;
    frame_dest_group <= ~grp;
  endtask
endmodule

// [rx_frame_stat_counters_bench.sv]
module rx_frame_stat_counters_bench
  import rfsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Narrow counters make saturation reachable in a few frames.
  localparam int CW = 3;
  localparam logic [15:0] CMAX = 16'h0007;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [31:0] rd_data;
  logic frame_done, frame_residual_bits, frame_dest_group;
  logic [15:0] frame_length;
  logic length_error, irq;
  logic [15:0] exp_cnt [4] = '{4{16'h0}};
  logic [15:0] max_len = RFSC_MAX_LEN_RESET;
  int n_mismatch = 0;
  int checked = 0;

  always #5 clock = ~clock;

  rfsc_frame_source src (.clock(clock), .frame_done(frame_done),
    .frame_length(frame_length), .frame_residual_bits(frame_residual_bits),
    .frame_dest_group(frame_dest_group));

  rfsc_rx_stat_counters #(.COUNT_WIDTH(CW)) uut (.clock(clock), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .frame_done(frame_done),
    .frame_length(frame_length), .frame_residual_bits(frame_residual_bits),
    .frame_dest_group(frame_dest_group), .length_error(length_error),
    .irq(irq));

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string what);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 check(what, rd_data, e);
  endtask

  task automatic bump(input int i);
    if (exp_cnt[i] != CMAX) exp_cnt[i]++;
  endtask

  task automatic rd_all;
    for (int i = 0; i < 4; i++) begin
      rd(RFSC_CNT_OFFSET[i], {16'h0, exp_cnt[i]}, "count");
    end
  endtask

  // Sends one verdict and checks the length flag in the cycle after it.
  task automatic frame(input logic [15:0] len, input logic res, grp);
    logic sh;
    logic lg;
    sh = len < RFSC_SHORT_LIMIT;
    lg = len > max_len;
    src.send(len, res, grp, 1);
    #1 check("length_error", {31'h0, length_error}, {31'h0, sh | lg});
    if (sh) bump(RFSC_EV_SHORT);
    if (lg && !res) bump(RFSC_EV_LONG);
    if (res) bump(RFSC_EV_PARTIAL);
    if (grp) bump(RFSC_EV_GROUP);
    @(posedge clock);
  endtask

  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd_all();
    rd(RFSC_OFF_MAX_LEN, 32'h0000_05ee, "max_len");
    rd(8'h1c, 32'h0, "unmapped");
    frame(16'd63, 1'b0, 1'b0);
    frame(16'd64, 1'b0, 1'b0);
    frame(16'd1518, 1'b0, 1'b1);
    frame(16'd1519, 1'b0, 1'b0);
    frame(16'd1600, 1'b1, 1'b0);
    frame(16'd20, 1'b1, 1'b1);
    rd_all();
    rd(RFSC_OFF_STATUS, 32'h10, "status");
    wr(RFSC_OFF_MAX_LEN, 32'd100);
    max_len = 16'd100;
    frame(16'd101, 1'b0, 1'b0);
    frame(16'd100, 1'b0, 1'b0);
    // Nine verdicts on consecutive cycles drive the group count into saturation at max.
    src.send(16'd80, 1'b0, 1'b1, 9);
    for (int i = 0; i < 9; i++) bump(RFSC_EV_GROUP);
    repeat (2) @(posedge clock);
    rd_all();
    check("irq_masked", {31'h0, irq}, 32'h0);
    rd(RFSC_OFF_STATUS, 32'h18, "status");
    wr(RFSC_OFF_GROUP, 32'h0000_1234);
    exp_cnt[RFSC_EV_GROUP] = 16'h0;
    rd(RFSC_OFF_GROUP, 32'h0, "group");
    fork
      src.send(16'd10, 1'b0, 1'b0, 1);
      begin
        @(posedge clock);
        wr(RFSC_OFF_SHORT, 32'h0);
      end
    join
    exp_cnt[RFSC_EV_SHORT] = 16'h0;
    repeat (2) @(posedge clock);
    rd(RFSC_OFF_SHORT, 32'h0, "short");
    rd(RFSC_OFF_STATUS, 32'h10, "status");
    wr(RFSC_OFF_MASK, 32'h10);
    frame(16'd30, 1'b0, 1'b0);
    #1 check("irq_set", {31'h0, irq}, 32'h1);
    rd(RFSC_OFF_STATUS, 32'h10, "status");
    check("irq_clear", {31'h0, irq}, 32'h0);
    wr(RFSC_OFF_MASK, 32'h0);
    frame(16'd30, 1'b0, 1'b0);
    wr(RFSC_OFF_MASK, 32'h10);
    #1 check("irq_unmask", {31'h0, irq}, 32'h1);
    rd(RFSC_OFF_STATUS, 32'h10, "status");
    rd_all();
    summarize();
  end
endmodule
